/* include/fsl_pkg.sv */
// Package with constants and types for the fieldbus status LED logic.
// Functional notes
// - Start fieldbus operation automatically after power-up.
// - Port one LED: steady link, flash traffic.
// - Port two LED behaves like port one.
// - State LED dark when unpowered or inactive.
// - Inactive without traffic for timeout: basic Ethernet.
// - State LED red during controller fault.
// - Flicker green without traffic; traffic enters preop1.
// - Preop1 shows repeated single green flash.
// - Preop2 shows repeated double short flash.
// - Ready state shows repeated triple short flash.
// - Operational shows steady green.
// - Stopped shows distinct green blinking.
package fsl_pkg;

	// Clock rate in kHz.
	localparam int unsigned CLK_KHZ       = 50_000;
	// Timeout without protocol traffic, in ms.
	localparam int unsigned IDLE_TMO_MS   = 5_000;
	localparam int unsigned IDLE_TMO_CYC  = IDLE_TMO_MS * CLK_KHZ;
	// Pattern tick period in ms; every pattern step lasts whole ticks.
	localparam int unsigned TICK_MS       = 50;
	localparam int unsigned TICK_CYC      = TICK_MS * CLK_KHZ;
	// Pattern durations in ticks.
	localparam logic [4:0]  FLASH_ON_TK   = 5'h04;
	localparam logic [4:0]  SHORT_ON_TK   = 5'h04;
	localparam logic [4:0]  SHORT_OFF_TK  = 5'h04;
	localparam logic [4:0]  GROUP_OFF_TK  = 5'h14;
	localparam logic [4:0]  BLINK_TK      = 5'h0a;
	// Traffic flash half period in ticks, less one.
	localparam logic [1:0]  ACT_TK        = 2'h1;
	// Cycles a state request waits for its echo in the controller report.
	localparam logic [2:0]  RPT_HOLD_CYC  = 3'h4;

	// Controller state reported by the protocol engine.
	typedef enum logic [3:0] {
		FSL_CTRL_NOT_ACTIVE = 4'h0,
		FSL_CTRL_PRE_OP1    = 4'h1,
		FSL_CTRL_PRE_OP2    = 4'h2,
		FSL_CTRL_READY      = 4'h3,
		FSL_CTRL_OPER       = 4'h4,
		FSL_CTRL_STOPPED    = 4'h5,
		FSL_CTRL_BASIC_ETH  = 4'h6
	} fsl_ctrl_t;

	// Indicator state machine, one-hot.
	typedef enum logic [6:0] {
		FSL_ST_INACTIVE = 7'b000_0001,
		FSL_ST_BASIC    = 7'b000_0010,
		FSL_ST_PRE_OP1  = 7'b000_0100,
		FSL_ST_PRE_OP2  = 7'b000_1000,
		FSL_ST_READY    = 7'b001_0000,
		FSL_ST_OPER     = 7'b010_0000,
		FSL_ST_STOPPED  = 7'b100_0000
	} fsl_state_t;

endpackage : fsl_pkg

/* hw/fsl_port_led.sv */
// Link and activity indicator for one bus port.
`timescale 1ns/1ps
module fsl_port_led
	import fsl_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic tick,
	input  wire logic link_up_pin,
	input  wire logic frame_pin,
	output logic      led_green
);

	typedef struct packed {
		logic [1:0] lnk_sync;
		logic [1:0] frm_sync;
		logic       frm_d;
		logic       busy;
		logic [1:0] cnt;
		logic [1:0] half;
		logic       led;
	} fsl_pl_t;

	fsl_pl_t st_r;
	fsl_pl_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Synchronise pins, catch frames and blink while traffic passes.
	always_comb begin
		st_nxt          = st_r;
		st_nxt.lnk_sync = {st_r.lnk_sync[0], link_up_pin};
		st_nxt.frm_sync = {st_r.frm_sync[0], frame_pin};
		st_nxt.frm_d    = st_r.frm_sync[1];
		// A frame edge arms one blink period.
		if (st_r.frm_sync[1] && !st_r.frm_d) begin
			st_nxt.busy = 1'b1;
		end
		if (tick) begin
			if (st_r.cnt == ACT_TK) begin
				st_nxt.cnt  = 2'h0;
				st_nxt.half = st_r.half + 2'h1;
				if (st_r.half[0]) begin
					st_nxt.busy = st_r.frm_sync[1] && !st_r.frm_d;
				end
			end else begin
				st_nxt.cnt = st_r.cnt + 2'h1;
			end
		end
		if (!st_r.lnk_sync[1]) begin
			st_nxt.led = 1'b0;
		end else if (st_r.busy) begin
			st_nxt.led = !st_r.half[0];
		end else begin
			st_nxt.led = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign led_green = st_r.led;

endmodule : fsl_port_led

/* hw/fsl_status_led.sv */
// Status indication top: state/error LED and both port LEDs.
`timescale 1ns/1ps
module fsl_status_led
	import fsl_pkg::*;
#(
	parameter int unsigned IDLE_TMO = IDLE_TMO_CYC,
	parameter int unsigned TICK_LEN = TICK_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       ctrl_powered,
	input  wire logic [3:0] ctrl_state,
	input  wire logic       ctrl_fault,
	input  wire logic       proto_seen,
	input  wire logic       p1_link_up,
	input  wire logic       p1_frame,
	input  wire logic       p2_link_up,
	input  wire logic       p2_frame,
	output logic            ctrl_enable,
	output logic            basic_eth_req,
	output logic            preop1_req,
	output logic            state_led_green,
	output logic            state_led_red,
	output logic            port1_link_activity_led,
	output logic            port2_link_activity_led
);

	typedef struct packed {
		logic       en;
		logic       basic;
		logic       pre1;
		logic [2:0] hold;
		logic [1:0] pw_s;
		logic [1:0] fl_s;
		logic [1:0] pr_s;
		logic [3:0] cs_s0;
		logic [3:0] cs_s1;
		logic [31:0] idle;
		logic [31:0] div;
		logic       tick;
		fsl_state_t fsm;
		logic [4:0] tk;
		logic [2:0] step;
		logic       phase_on;
		logic       grn;
		logic       red;
	} fsl_top_t;

	fsl_top_t st_r;
	fsl_top_t st_nxt;
	logic     pw;
	logic     flt;
	logic     seen;
	logic [1:0] flashes;
	logic       grp;

	////////////////////////////////////////////////////////////////////////
	// Synchronised views of the controller inputs.
	assign pw   = st_r.pw_s[1];
	assign flt  = st_r.fl_s[1];
	assign seen = st_r.pr_s[1];

	// Flash count per group for the current state.
	always_comb begin
		flashes = 2'h1;
		grp     = 1'b1;
		case (st_r.fsm)
			FSL_ST_PRE_OP1: flashes = 2'h1;
			FSL_ST_PRE_OP2: flashes = 2'h2;
			FSL_ST_READY:   flashes = 2'h3;
			default:        grp     = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		st_nxt       = st_r;
		st_nxt.pw_s  = {st_r.pw_s[0], ctrl_powered};
		st_nxt.fl_s  = {st_r.fl_s[0], ctrl_fault};
		st_nxt.pr_s  = {st_r.pr_s[0], proto_seen};
		st_nxt.cs_s0 = ctrl_state;
		st_nxt.cs_s1 = st_r.cs_s0;
		// Enable the controller straight out of reset.
		st_nxt.en    = 1'b1;
		st_nxt.basic = 1'b0;
		st_nxt.pre1  = 1'b0;

		// Pattern tick divider.
		st_nxt.tick = 1'b0;
		if (st_r.div >= TICK_LEN - 1) begin
			st_nxt.div  = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.div = st_r.div + 32'h0000_0001;
		end

		// Indicator state follows the reported controller state.
		// After a request of our own the report lags by the sync flops,
		// so it is ignored until the echo can arrive; a stale report
		// would otherwise pull the state back and repeat the request.
		if (st_r.hold != 3'h0) begin
			st_nxt.hold = st_r.hold - 3'h1;
		end else begin
			case (fsl_ctrl_t'(st_r.cs_s1))
				FSL_CTRL_NOT_ACTIVE: begin
					if (st_r.fsm != FSL_ST_BASIC) begin
						st_nxt.fsm = FSL_ST_INACTIVE;
					end
				end
				FSL_CTRL_BASIC_ETH: st_nxt.fsm = FSL_ST_BASIC;
				FSL_CTRL_PRE_OP1:   st_nxt.fsm = FSL_ST_PRE_OP1;
				FSL_CTRL_PRE_OP2:   st_nxt.fsm = FSL_ST_PRE_OP2;
				FSL_CTRL_READY:     st_nxt.fsm = FSL_ST_READY;
				FSL_CTRL_OPER:      st_nxt.fsm = FSL_ST_OPER;
				FSL_CTRL_STOPPED:   st_nxt.fsm = FSL_ST_STOPPED;
				default:            st_nxt.fsm = FSL_ST_INACTIVE;
			endcase
		end

		// Idle timer and protocol detection.
		case (st_r.fsm)
			FSL_ST_INACTIVE: begin
				if (seen) begin
					st_nxt.idle = '0;
					st_nxt.hold = RPT_HOLD_CYC;
					st_nxt.pre1 = 1'b1;
					st_nxt.fsm  = FSL_ST_PRE_OP1;
				end else if (st_r.idle >= IDLE_TMO - 1) begin
					st_nxt.idle  = '0;
					st_nxt.hold  = RPT_HOLD_CYC;
					st_nxt.basic = 1'b1;
					st_nxt.fsm   = FSL_ST_BASIC;
				end else if (pw) begin
					st_nxt.idle = st_r.idle + 32'h0000_0001;
				end
			end
			FSL_ST_BASIC: begin
				st_nxt.idle = '0;
				if (seen) begin
					st_nxt.hold = RPT_HOLD_CYC;
					st_nxt.pre1 = 1'b1;
					st_nxt.fsm  = FSL_ST_PRE_OP1;
				end
			end
			default: st_nxt.idle = '0;
		endcase
		// An unpowered controller takes no requests at all.
		if (!pw) begin
			st_nxt.fsm   = FSL_ST_INACTIVE;
			st_nxt.idle  = '0;
			st_nxt.hold  = '0;
			st_nxt.basic = 1'b0;
			st_nxt.pre1  = 1'b0;
		end

		// Pattern sequencer, restarted on state change.
		if (st_nxt.fsm != st_r.fsm) begin
			st_nxt.tk       = '0;
			st_nxt.step     = '0;
			st_nxt.phase_on = 1'b1;
		end else if (st_r.tick) begin
			st_nxt.tk = st_r.tk + 5'h01;
			if (grp) begin
				// Flash groups: on, short gap, long gap after last.
				if (st_r.phase_on && st_r.tk >= SHORT_ON_TK - 5'h01) begin
					st_nxt.tk       = '0;
					st_nxt.phase_on = 1'b0;
				end else if (!st_r.phase_on) begin
					if ({1'b0, st_r.step} + 3'h1 < {1'b0, flashes}) begin
						if (st_r.tk >= SHORT_OFF_TK - 5'h01) begin
							st_nxt.tk       = '0;
							st_nxt.step     = st_r.step + 3'h1;
							st_nxt.phase_on = 1'b1;
						end
					end else if (st_r.tk >= GROUP_OFF_TK - 5'h01) begin
						st_nxt.tk       = '0;
						st_nxt.step     = '0;
						st_nxt.phase_on = 1'b1;
					end
				end
			end else if (st_r.tk >= BLINK_TK - 5'h01) begin
				st_nxt.tk       = '0;
				st_nxt.phase_on = !st_r.phase_on;
			end
		end

		// LED outputs; fault red overrides green.
		st_nxt.red = pw && flt;
		case (st_r.fsm)
			FSL_ST_INACTIVE: st_nxt.grn = 1'b0;
			FSL_ST_BASIC:    st_nxt.grn = st_r.tk[0];
			FSL_ST_OPER:     st_nxt.grn = 1'b1;
			FSL_ST_STOPPED:  st_nxt.grn = st_r.phase_on;
			FSL_ST_PRE_OP1,
			FSL_ST_PRE_OP2,
			FSL_ST_READY:    st_nxt.grn = st_r.phase_on;
			default:         st_nxt.grn = 1'b0;
		endcase
		if (st_nxt.red) begin
			st_nxt.grn = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_r     <= '0;
			st_r.fsm <= FSL_ST_INACTIVE;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port indicators.
	fsl_port_led u_port1 (
		.mclk        (mclk),
		.rstn        (rstn),
		.tick        (st_r.tick),
		.link_up_pin (p1_link_up),
		.frame_pin   (p1_frame),
		.led_green   (port1_link_activity_led)
	);

	fsl_port_led u_port2 (
		.mclk        (mclk),
		.rstn        (rstn),
		.tick        (st_r.tick),
		.link_up_pin (p2_link_up),
		.frame_pin   (p2_frame),
		.led_green   (port2_link_activity_led)
	);

	assign ctrl_enable     = st_r.en;
	assign basic_eth_req   = st_r.basic;
	assign preop1_req      = st_r.pre1;
	assign state_led_green = st_r.grn;
	assign state_led_red   = st_r.red;

endmodule : fsl_status_led

/* bench/fsl_status_led_assertions.sv */
// Checker for the ports of the status LED top.
`timescale 1ns/1ps
module fsl_status_led_chk
	import fsl_pkg::*;
#(
	parameter int unsigned IDLE_TMO = IDLE_TMO_CYC,
	parameter int unsigned TICK_LEN = TICK_CYC
) (
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic       ctrl_powered,
	input wire logic [3:0] ctrl_state,
	input wire logic       ctrl_fault,
	input wire logic       proto_seen,
	input wire logic       p1_link_up,
	input wire logic       p1_frame,
	input wire logic       p2_link_up,
	input wire logic       p2_frame,
	input wire logic       ctrl_enable,
	input wire logic       basic_eth_req,
	input wire logic       preop1_req,
	input wire logic       state_led_green,
	input wire logic       state_led_red,
	input wire logic       port1_link_activity_led,
	input wire logic       port2_link_activity_led
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// Inputs held long enough to pass the sync flops and the state machine.
	sequence s_unpowered;
		!ctrl_powered [*6];
	endsequence
	sequence s_faulted;
		(ctrl_fault && ctrl_powered) [*6];
	endsequence
	sequence s_oper;
		(ctrl_state == FSL_CTRL_OPER && ctrl_powered && !ctrl_fault) [*6];
	endsequence
	a_enable_held: assert property ($past(rstn) |-> ctrl_enable)
		else $error("enable dropped");
	a_dark_unpowered: assert property (s_unpowered |->
		!state_led_green && !state_led_red) else $error("state led lit");
	a_fault_red: assert property (s_faulted |-> state_led_red)
		else $error("red missing");
	a_red_excl_green: assert property (state_led_red |-> !state_led_green)
		else $error("red with green");
	a_oper_steady: assert property (s_oper |-> state_led_green)
		else $error("green missing");
	a_port1_nolink: assert property (!p1_link_up [*6] |->
		!port1_link_activity_led) else $error("port one lit");
	a_port2_nolink: assert property (!p2_link_up [*6] |->
		!port2_link_activity_led) else $error("port two lit");
	a_basic_pulse: assert property (basic_eth_req |=> !basic_eth_req)
		else $error("basic request long");
	a_preop_pulse: assert property (preop1_req |=> !preop1_req)
		else $error("preop request long");
endmodule : fsl_status_led_chk
bind fsl_status_led fsl_status_led_chk #(.IDLE_TMO(IDLE_TMO),
	.TICK_LEN(TICK_LEN)) chk_u (.mclk, .rstn, .ctrl_powered, .ctrl_state,
	.ctrl_fault, .proto_seen, .p1_link_up, .p1_frame, .p2_link_up,
	.p2_frame, .ctrl_enable, .basic_eth_req, .preop1_req, .state_led_green,
	.state_led_red, .port1_link_activity_led, .port2_link_activity_led);

/* bench/fsl_node_model.sv */
// Far-side model: the controller state report.
`timescale 1ns/1ps
module fsl_node_model
	import fsl_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       ctrl_enable,
	input  wire logic       basic_eth_req,
	input  wire logic       preop1_req,
	input  wire logic       cmd_load,
	input  wire logic [3:0] cmd_state,
	output logic [3:0]      ctrl_state
);
	// The report clears while ctrl_enable is low, moves on a request or a command and holds otherwise.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn || !ctrl_enable) begin
			ctrl_state <= FSL_CTRL_NOT_ACTIVE;
		end else if (basic_eth_req) begin
			ctrl_state <= FSL_CTRL_BASIC_ETH;
		end else if (preop1_req) begin
			ctrl_state <= FSL_CTRL_PRE_OP1;
		end else if (cmd_load) begin
			ctrl_state <= cmd_state;
		end
	end
endmodule : fsl_node_model

/* bench/tb_top.sv */
// Self-checking testbench for the status LED top.
`timescale 1ns/1ps
module tb_top
	import fsl_pkg::*;
;
	logic       mclk, rstn, ctrl_powered, ctrl_fault, proto_seen, cmd_load;
	logic       p1_link_up, p1_frame, p2_link_up, p2_frame;
	logic [3:0] ctrl_state, cmd_state;
	logic       ctrl_enable, basic_eth_req, preop1_req, p;
	logic       state_led_green, state_led_red;
	logic       port1_link_activity_led, port2_link_activity_led;
	logic [1:0] trf;
	logic [2:0] obs;
	int         miscompares, total_checks, seed, i, c;
	int         plen[1:5] = '{96, 128, 160, 50, 80};
	int         pcnt[1:5] = '{1, 2, 3, 0, 1};
	logic [1:0] exp_q[$];
	assign obs = {port2_link_activity_led, port1_link_activity_led,
		state_led_green};
	fsl_status_led #(.IDLE_TMO(200), .TICK_LEN(4)) dut_u (.mclk, .rstn,
		.ctrl_powered, .ctrl_state, .ctrl_fault, .proto_seen, .p1_link_up,
		.p1_frame, .p2_link_up, .p2_frame, .ctrl_enable, .basic_eth_req,
		.preop1_req, .state_led_green, .state_led_red,
		.port1_link_activity_led, .port2_link_activity_led);
	fsl_node_model node_u (.mclk, .rstn, .ctrl_enable, .basic_eth_req,
		.preop1_req, .cmd_load, .cmd_state, .ctrl_state);
	////////////////////////////////////////////////////////////////////////
	// Clock at 50 MHz.
	initial begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	// Random frame activity on ports whose traffic is switched on.
	always @(posedge mclk) begin
		#2 {p2_frame, p1_frame} = trf & 2'($random(seed));
	end
	// Each request pulse takes the oldest expected note.
	always @(posedge mclk) begin
		if (rstn && (basic_eth_req || preop1_req)) begin
			if (exp_q.size() == 0) chk_ev(2'h0, {preop1_req, basic_eth_req});
			else chk_ev(exp_q.pop_front(), {preop1_req, basic_eth_req});
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : cyc
	task automatic bad(input string nm, input int e, input int s);
		miscompares++;
		$display("unexpected %s exp %0d got %0d", nm, e, s);
	endtask : bad
	task automatic chk(input string nm, input logic e, input logic s);
		total_checks++;
		if (s !== e) bad(nm, e, s);
	endtask : chk
	task automatic chk_n(input string nm, input int e, input int s);
		total_checks++;
		if (s != e) bad(nm, e, s);
	endtask : chk_n
	task automatic chk_ev(input logic [1:0] e, input logic [1:0] s);
		total_checks++;
		if (s !== e) bad("request", e, s);
	endtask : chk_ev
	task automatic wrap_up;
		if (miscompares == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up
	task automatic wait_ev(input int n);
		while (exp_q.size() != 0 && n > 0) begin
			cyc(1);
			n--;
		end
		if (exp_q.size() != 0) bad("request wait", 0, n);
		if (exp_q.size() != 0) wrap_up();
	endtask : wait_ev
	// Counts rising edges of one observed LED over a window.
	task automatic rises(input int sel, input int n, output int cnt);
		logic q;
		cnt = 0;
		q = obs[sel];
		repeat (n) begin
			cyc(1);
			if (obs[sel] && !q) cnt++;
			q = obs[sel];
		end
	endtask : rises
	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		seed = 57;
		{ctrl_powered, ctrl_fault, proto_seen, cmd_load, trf} = 6'h20;
		{p1_link_up, p2_link_up, rstn} = 3'h0;
		cmd_state = 4'h0;
		repeat (12) @(posedge mclk);
		#2 rstn = 1;
		cyc(2);
		chk("ctrl_enable", 1'b1, ctrl_enable);
		exp_q.push_back(2'h1);
		wait_ev(400);
		cyc(8);
		p = state_led_green;
		cyc(4);
		chk("flicker", !p, state_led_green);
		proto_seen = 1;
		exp_q.push_back(2'h2);
		wait_ev(20);
		for (i = 1; i < 6; i++) begin
			cmd_state = 4'(i);
			cmd_load = 1;
			cyc(1);
			cmd_load = 0;
			cyc(200);
			rises(0, plen[i], c);
			chk_n("flash_count", pcnt[i], c);
			if (i == 4) chk("steady", 1'b1, state_led_green);
		end
		ctrl_fault = 1;
		cyc(8);
		chk("red", 1'b1, state_led_red);
		chk("green", 1'b0, state_led_green);
		ctrl_fault = 0;
		ctrl_powered = 0;
		proto_seen = 0;
		cyc(8);
		chk("dark", 1'b0, state_led_green | state_led_red);
		ctrl_powered = 1;
		for (i = 1; i < 3; i++) begin
			chk("port_dark", 1'b0, obs[i]);
			{p2_link_up, p1_link_up} = 2'(i);
			cyc(40);
			chk("port_link", 1'b1, obs[i]);
			trf = 2'(i);
			rises(i, 64, c);
			chk("port_traffic", 1'b1, c > 0);
			trf = 0;
			{p2_link_up, p1_link_up} = 0;
			cyc(40);
		end
		wrap_up();
	end
endmodule : tb_top
